/* File: rtl/ssum_pkg.sv */
// shared constants and types of the status and event summary block
package ssum_pkg;

  // ****************************************************************
  // status byte bit positions
  // ****************************************************************
  localparam int unsigned STB_XQ_BIT   = 1;
  localparam int unsigned STB_EQ_BIT   = 2;
  localparam int unsigned STB_QUES_BIT = 3;
  localparam int unsigned STB_MAV_BIT  = 4;
  localparam int unsigned STB_ESB_BIT  = 5;
  localparam int unsigned STB_MSS_BIT  = 6;
  localparam int unsigned STB_OPER_BIT = 7;

  // ****************************************************************
  // event latch bit positions and reset values
  // ****************************************************************
  localparam int unsigned ESR_OPC_BIT = 0;
  localparam int unsigned ESR_QRY_BIT = 2;
  localparam int unsigned ESR_DDE_BIT = 3;
  localparam int unsigned ESR_EXE_BIT = 4;
  localparam int unsigned ESR_CME_BIT = 5;
  localparam int unsigned ESR_URQ_BIT = 6;
  localparam logic [7:0]  ESR_USED    = 8'h7D;
  localparam logic [7:0]  PPE_RESET   = 8'h00;
  localparam logic [7:0]  ESE_RESET   = 8'h00;
  localparam logic [7:0]  ESR_RESET   = 8'h00;
  localparam logic [7:0]  STB_RESET   = 8'h00;

  // ****************************************************************
  // error queue defaults
  // ****************************************************************
  localparam int unsigned ERRQ_DEPTH    = 16;
  localparam int unsigned ERR_CODE_W    = 16;
  localparam logic [15:0] ERR_NONE_CODE = 16'h0000;
  localparam logic [15:0] ERR_OVFL_CODE = 16'hFEA2;

  // ****************************************************************
  // command and answer carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    SSUM_OP_NONE   = 3'h0,
    SSUM_OP_PPE_WR = 3'h1,
    SSUM_OP_PPE_RD = 3'h2,
    SSUM_OP_ESE_WR = 3'h3,
    SSUM_OP_ESE_RD = 3'h4,
    SSUM_OP_ESR_RD = 3'h5,
    SSUM_OP_STB_RD = 3'h6,
    SSUM_OP_ERR_RD = 3'h7
  } ssum_op_t;

  typedef struct packed {
    logic       valid;
    ssum_op_t   op;
    logic [7:0] data;
  } ssum_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ssum_rsp_t;

  typedef struct packed {
    logic cmd_err;
    logic exe_err;
    logic dev_err;
    logic qry_err;
    logic opc_cmd;
    logic user_req;
  } ssum_evt_t;

  typedef struct packed {
    logic oper;
    logic mss;
    logic mav;
    logic ques;
  } ssum_stb_ext_t;

endpackage

/* File: rtl/ssum_err_queue.sv */
// error queue: first in first out store of descriptive error codes
`timescale 1ns/1ps
`default_nettype none
module ssum_err_queue
  import ssum_pkg::*;
#(
  parameter int unsigned DEPTH = ERRQ_DEPTH,
  parameter int unsigned W     = ERR_CODE_W
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         push,
  input  wire logic [W-1:0] push_code,
  input  wire logic         pop,
  output logic     [W-1:0]  head_code,
  output logic              not_empty,
  output logic              pushed
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          full;
  logic          do_pop;
  logic          do_push;
  logic [AW-1:0] last;

  assign full      = (cnt_q == (AW+1)'(DEPTH));
  assign not_empty = (cnt_q != '0);
  assign do_pop    = pop && not_empty;
  // a full queue keeps its oldest entries; the newest slot says overflow
  assign do_push   = push && (!full || do_pop);
  assign pushed    = do_push;
  assign last      = wr_q - AW'(1);
  assign head_code = not_empty ? mem[rd_q] : W'(ERR_NONE_CODE);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_q] <= push_code;
    end else if (push && full) begin
      mem[last] <= W'(ERR_OVFL_CODE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + AW'(1);
      if (do_pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ssum_event_latch.sv */
// sticky event latch with enable mask and summary output
`timescale 1ns/1ps
`default_nettype none
module ssum_event_latch
  import ssum_pkg::*;
#(
  parameter int unsigned W        = 8,
  parameter logic [7:0]  USED     = ESR_USED
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] set_vec,
  input  wire logic         clr,
  input  wire logic [W-1:0] enable,
  output logic     [W-1:0]  value_q,
  output logic              summary
);
  logic [W-1:0] value_d;

  // an event in the clearing cycle survives the clear
  assign value_d = ((clr ? '0 : value_q) | set_vec) & USED[W-1:0];
  assign summary = |(value_q & enable);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) value_q <= ESR_RESET[W-1:0];
    else value_q <= value_d;
  end
endmodule
`default_nettype wire

/* File: rtl/ssum_status_event_summary.sv */
// status byte, event latch, masks and parallel poll summary
//
// How it works
// - stb bit 2 follows error queue non-empty
// - enabled bit 2 requests service per entry
// - stb bit 1 is enabled questionable summary
// - ist is or of stb bits masked by ppe
// - parallel poll answers with ist bit
// - ppe mask written and read back unchanged
// - esr query returns then clears latch
// - ese mask written and readable
// - stb bit 5 is enabled event summary
// - command error sets event bit 5
// - execution error sets event bit 4
// - device fault sets event bit 3
// - command, execution or device errors queue one code per cycle, shared by simultaneous errors
// - query error sets event bit 2
// - opc sets bit 0 after completion
`timescale 1ns/1ps
`default_nettype none
module ssum_status_event_summary
  import ssum_pkg::*;
#(
  parameter int unsigned ERR_DEPTH = ERRQ_DEPTH,
  parameter int unsigned XQ_W      = 16
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire ssum_cmd_t             cmd,
  input  wire ssum_evt_t             evt,
  input  wire logic [ERR_CODE_W-1:0] err_code,
  input  wire logic [XQ_W-1:0]       xq_event,
  input  wire logic [XQ_W-1:0]       xq_enable,
  input  wire ssum_stb_ext_t         stb_ext,
  input  wire logic                  sre_eq_en,
  input  wire logic                  all_done,
  input  wire logic                  ppoll_req,
  output ssum_rsp_t                  rsp_q,
  output logic [7:0]                 stb_q,
  output logic                       ist_q,
  output logic                       ppoll_valid_q,
  output logic                       ppoll_ist_q,
  output logic                       srq_q
);

  // ****************************************************************
  // command decode
  // ****************************************************************
  wire ppe_wr = cmd.valid && (cmd.op == SSUM_OP_PPE_WR);
  wire ppe_rd = cmd.valid && (cmd.op == SSUM_OP_PPE_RD);
  wire ese_wr = cmd.valid && (cmd.op == SSUM_OP_ESE_WR);
  wire ese_rd = cmd.valid && (cmd.op == SSUM_OP_ESE_RD);
  wire esr_rd = cmd.valid && (cmd.op == SSUM_OP_ESR_RD);
  wire stb_rd = cmd.valid && (cmd.op == SSUM_OP_STB_RD);
  wire err_rd = cmd.valid && (cmd.op == SSUM_OP_ERR_RD);
  wire any_rd = ppe_rd || ese_rd || esr_rd || stb_rd || err_rd;

  // ****************************************************************
  // mask registers
  // ****************************************************************
  logic [7:0] ppe_q;
  logic [7:0] ppe_d;
  logic [7:0] ese_q;
  logic [7:0] ese_d;

  // masks keep every bit as written, unused positions included
  assign ppe_d = ppe_wr ? cmd.data : ppe_q;
  assign ese_d = ese_wr ? cmd.data : ese_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ppe_q <= PPE_RESET;
      ese_q <= ESE_RESET;
    end else begin
      ppe_q <= ppe_d;
      ese_q <= ese_d;
    end
  end

  // ****************************************************************
  // operation complete tracking
  // ****************************************************************
  typedef enum logic [1:0] {
    SSUM_OPC_IDLE = 2'b00,
    SSUM_OPC_WAIT = 2'b01
  } ssum_opc_state_t;

  ssum_opc_state_t opc_q;
  ssum_opc_state_t opc_d;
  logic            opc_done;

  // the wait starts the cycle after the command so that commands
  // accepted together with it are counted as previous ones
  always_comb begin
    opc_d    = opc_q;
    opc_done = 1'b0;
    unique case (opc_q)
      SSUM_OPC_IDLE: begin
        if (evt.opc_cmd) opc_d = SSUM_OPC_WAIT;
      end
      SSUM_OPC_WAIT: begin
        if (all_done) begin
          opc_done = 1'b1;
          opc_d    = evt.opc_cmd ? SSUM_OPC_WAIT : SSUM_OPC_IDLE;
        end
      end
      default: opc_d = SSUM_OPC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) opc_q <= SSUM_OPC_IDLE;
    else opc_q <= opc_d;
  end

  // ****************************************************************
  // event latch
  // ****************************************************************
  logic [7:0] esr_set;
  logic [7:0] esr_val;
  logic       esb;

  always_comb begin
    esr_set              = 8'h00;
    esr_set[ESR_OPC_BIT] = opc_done;
    esr_set[ESR_QRY_BIT] = evt.qry_err;
    esr_set[ESR_DDE_BIT] = evt.dev_err;
    esr_set[ESR_EXE_BIT] = evt.exe_err;
    esr_set[ESR_CME_BIT] = evt.cmd_err;
    esr_set[ESR_URQ_BIT] = evt.user_req;
  end

  ssum_event_latch #(
    .W    (8),
    .USED (ESR_USED)
  ) u_esr (
    .clk     (clk),
    .rst_b   (rst_b),
    .set_vec (esr_set),
    .clr     (esr_rd),
    .enable  (ese_q),
    .value_q (esr_val),
    .summary (esb)
  );

  // ****************************************************************
  // error queue
  // ****************************************************************
  logic                  err_push;
  logic                  err_pushed;
  logic                  err_pend;
  logic [ERR_CODE_W-1:0] err_head;

  // one entry per cycle; simultaneous errors share one code
  assign err_push = evt.cmd_err || evt.exe_err || evt.dev_err;

  ssum_err_queue #(
    .DEPTH (ERR_DEPTH),
    .W     (ERR_CODE_W)
  ) u_errq (
    .clk       (clk),
    .rst_b     (rst_b),
    .push      (err_push),
    .push_code (err_code),
    .pop       (err_rd),
    .head_code (err_head),
    .not_empty (err_pend),
    .pushed    (err_pushed)
  );

  // ****************************************************************
  // status byte
  // ****************************************************************
  logic [7:0] stb_d;
  logic       xq_sum;

  assign xq_sum = |(xq_event & xq_enable);

  always_comb begin
    stb_d               = 8'h00;
    stb_d[STB_XQ_BIT]   = xq_sum;
    stb_d[STB_EQ_BIT]   = err_pend;
    stb_d[STB_QUES_BIT] = stb_ext.ques;
    stb_d[STB_MAV_BIT]  = stb_ext.mav;
    stb_d[STB_ESB_BIT]  = esb;
    stb_d[STB_MSS_BIT]  = stb_ext.mss;
    stb_d[STB_OPER_BIT] = stb_ext.oper;
  end

  // ****************************************************************
  // ist flag and parallel poll
  // ****************************************************************
  logic ist_d;

  // bit 6 takes part here, unlike the service request mask
  assign ist_d = |(stb_q & ppe_q);

  // ****************************************************************
  // answers
  // ****************************************************************
  logic [15:0] rd_data;

  always_comb begin
    rd_data = 16'h0000;
    unique case (1'b1)
      ppe_rd:  rd_data = {8'h00, ppe_q};
      ese_rd:  rd_data = {8'h00, ese_q};
      esr_rd:  rd_data = {8'h00, esr_val};
      stb_rd:  rd_data = {8'h00, stb_q};
      err_rd:  rd_data = 16'(err_head);
      default: rd_data = 16'h0000;
    endcase
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_q         <= '0;
      stb_q         <= STB_RESET;
      ist_q         <= 1'b0;
      ppoll_valid_q <= 1'b0;
      ppoll_ist_q   <= 1'b0;
      srq_q         <= 1'b0;
    end else begin
      rsp_q.valid   <= any_rd;
      rsp_q.data    <= rd_data;
      stb_q         <= stb_d;
      ist_q         <= ist_d;
      ppoll_valid_q <= ppoll_req;
      ppoll_ist_q   <= ppoll_req && ist_d;
      srq_q         <= err_pushed && sre_eq_en;
    end
  end

endmodule
`default_nettype wire

/* File: tb/ssum_chk.sv */
// port assertions of the status and event summary block
`timescale 1ns/1ps
`default_nettype none
module ssum_chk
  import ssum_pkg::*;
#(
  parameter int unsigned XQ_W = 16
) (
  input wire logic            clk,
  input wire logic            rst_b,
  input wire ssum_cmd_t       cmd,
  input wire ssum_evt_t       evt,
  input wire logic [XQ_W-1:0] xq_event,
  input wire logic [XQ_W-1:0] xq_enable,
  input wire logic            sre_eq_en,
  input wire logic            ppoll_req,
  input wire ssum_rsp_t       rsp_q,
  input wire logic [7:0]      stb_q,
  input wire logic            ist_q,
  input wire logic            ppoll_valid_q,
  input wire logic            ppoll_ist_q,
  input wire logic            srq_q
);
  wire logic rd_op  = cmd.valid && cmd.op inside {SSUM_OP_PPE_RD,
    SSUM_OP_ESE_RD, SSUM_OP_ESR_RD, SSUM_OP_STB_RD, SSUM_OP_ERR_RD};
  wire logic esr_rd = cmd.valid && cmd.op == SSUM_OP_ESR_RD;
  wire logic err    = evt.cmd_err || evt.exe_err || evt.dev_err;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rd_answer: assert property (rd_op |=> rsp_q.valid)
    else $error("read got no answer");
  a_upper_zero: assert property (rd_op && cmd.op != SSUM_OP_ERR_RD
    |=> rsp_q.data[15:8] == 8'h00) else $error("upper answer byte set");
  a_stb_unused: assert property (stb_q[0] == 1'b0)
    else $error("status bit 0 set");
  a_esr_unused: assert property (esr_rd |=> !rsp_q.data[7]
    && !rsp_q.data[1]) else $error("unused event bit read as one");
  a_xq_summary: assert property ($past(rst_b) |-> stb_q[1] ==
    $past(|(xq_event & xq_enable))) else $error("questionable summary");
  a_ist_poll: assert property (ppoll_req |=> ppoll_valid_q
    && ppoll_ist_q == ist_q) else $error("poll answer wrong");
  a_poll_quiet: assert property (!ppoll_req |=> !ppoll_valid_q)
    else $error("poll answer without request");
  a_eq_bit: assert property (err |-> ##2 stb_q[2])
    else $error("queue bit not set after error");
  a_srq_cause: assert property (!(err && sre_eq_en) |=> !srq_q)
    else $error("service request without new entry");
  a_esr_clear: assert property ((esr_rd && evt == '0) ##1
    (evt == '0) ##1 esr_rd |=> rsp_q.data[7:1] == 7'h00)
    else $error("event latch not cleared by read");
  c_poll: cover property (ppoll_valid_q && ppoll_ist_q);
  c_srq: cover property (srq_q);
  c_esr: cover property (esr_rd);
endmodule
bind ssum_status_event_summary ssum_chk #(.XQ_W(XQ_W)) i_ssum_chk (
  .clk(clk), .rst_b(rst_b), .cmd(cmd), .evt(evt), .xq_event(xq_event),
  .xq_enable(xq_enable), .sre_eq_en(sre_eq_en), .ppoll_req(ppoll_req),
  .rsp_q(rsp_q), .stb_q(stb_q), .ist_q(ist_q),
  .ppoll_valid_q(ppoll_valid_q), .ppoll_ist_q(ppoll_ist_q), .srq_q(srq_q)
);
`default_nettype wire

/* File: tb/ssum_ctrl_model.sv */
// remote controller model: sends commands and parallel polls
`timescale 1ns/1ps
`default_nettype none
module ssum_ctrl_model
  import ssum_pkg::*;
(
  input  wire logic      clk,
  input  wire ssum_rsp_t rsp_q,
  input  wire logic      ppoll_valid_q,
  input  wire logic      ppoll_ist_q,
  output ssum_cmd_t      cmd,
  output logic           ppoll_req
);
  initial begin
    cmd       = '0;
    ppoll_req = 1'b0;
  end
  // one command per call, so error entries leave one at a time
  task automatic send(input ssum_op_t op, input logic [7:0] d,
                      output logic [15:0] r);
    @(negedge clk);
    cmd = '{1'b1, op, d};
    @(negedge clk);
    cmd = '0;
    r = rsp_q.valid ? rsp_q.data : 16'hXXXX;
  endtask
  task automatic poll(output logic [15:0] r);
    @(negedge clk);
    ppoll_req = 1'b1;
    @(negedge clk);
    ppoll_req = 1'b0;
    r = {14'h0000, ppoll_valid_q, ppoll_ist_q};
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of the status and event summary block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssum_pkg::*;
  logic          clk, rst_b, sre_eq_en, all_done, ppoll_req;
  logic          ist_q, ppoll_valid_q, ppoll_ist_q, srq_q;
  ssum_cmd_t     cmd;
  ssum_evt_t     evt;
  ssum_rsp_t     rsp_q;
  ssum_stb_ext_t stb_ext;
  logic [15:0]   err_code, xq_event, xq_enable, r, n;
  logic [7:0]    stb_q;
  int            bad_count = 0;
  int            cmp_count = 0;
  localparam logic [7:0] ESR_EXP [6] = '{8'h20, 8'h10, 8'h08, 8'h04,
                                         8'h01, 8'h40};

  ssum_status_event_summary #(.ERR_DEPTH(4), .XQ_W(16))
  i_ssum_status_event_summary (
    .clk(clk), .rst_b(rst_b), .cmd(cmd), .evt(evt), .err_code(err_code),
    .xq_event(xq_event), .xq_enable(xq_enable), .stb_ext(stb_ext),
    .sre_eq_en(sre_eq_en), .all_done(all_done), .ppoll_req(ppoll_req),
    .rsp_q(rsp_q), .stb_q(stb_q), .ist_q(ist_q),
    .ppoll_valid_q(ppoll_valid_q), .ppoll_ist_q(ppoll_ist_q), .srq_q(srq_q)
  );
  ssum_ctrl_model i_ssum_ctrl_model (
    .clk(clk), .rsp_q(rsp_q), .ppoll_valid_q(ppoll_valid_q),
    .ppoll_ist_q(ppoll_ist_q), .cmd(cmd), .ppoll_req(ppoll_req)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input ssum_op_t op, input logic [15:0] e);
    i_ssum_ctrl_model.send(op, 8'h00, r);
    chk(r, e);
  endtask
  task automatic wr(input ssum_op_t op, input logic [7:0] d);
    i_ssum_ctrl_model.send(op, d, r);
  endtask
  task automatic pe(input ssum_evt_t e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = '0;
  endtask
  task automatic pl(input logic [15:0] e);
    repeat (2) @(negedge clk);
    i_ssum_ctrl_model.poll(r);
    chk(r, e);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    {rst_b, evt, err_code, xq_event, xq_enable, stb_ext, sre_eq_en} = '0;
    all_done = 1'b1;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(SSUM_OP_PPE_RD, 16'h0000);
    rd(SSUM_OP_ESE_RD, 16'h0000);
    wr(SSUM_OP_PPE_WR, 8'hA5);
    rd(SSUM_OP_PPE_RD, 16'h00A5);
    wr(SSUM_OP_ESE_WR, 8'hFF);
    rd(SSUM_OP_ESE_RD, 16'h00FF);
    for (int i = 0; i < 6; i++) begin
      err_code = 16'h0100 + 16'(i);
      pe(ssum_evt_t'(6'h20 >> i));
      repeat (4) @(negedge clk);
      chk(16'(stb_q[5]), 16'h0001);
      rd(SSUM_OP_ESR_RD, 16'(ESR_EXP[i]));
      rd(SSUM_OP_ESR_RD, 16'h0000);
    end
    chk(16'(stb_q[2]), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      rd(SSUM_OP_ERR_RD, 16'h0100 + 16'(i));
    end
    repeat (2) @(negedge clk);
    chk(16'(stb_q[2]), 16'h0000);
    rd(SSUM_OP_ERR_RD, ERR_NONE_CODE);
    wr(SSUM_OP_ESE_WR, 8'hBF);
    pe(ssum_evt_t'(6'h01));
    repeat (3) @(negedge clk);
    chk(16'(stb_q[5]), 16'h0000);
    wr(SSUM_OP_ESE_WR, 8'h40);
    repeat (2) @(negedge clk);
    chk(16'(stb_q[5]), 16'h0001);
    rd(SSUM_OP_ESR_RD, 16'h0040);
    xq_event = 16'h8000;
    repeat (2) @(negedge clk);
    chk(16'(stb_q[1]), 16'h0000);
    xq_enable = 16'h8000;
    repeat (2) @(negedge clk);
    chk(16'(stb_q[1]), 16'h0001);
    wr(SSUM_OP_PPE_WR, 8'h01);
    pl(16'h0002);
    wr(SSUM_OP_PPE_WR, 8'h02);
    pl(16'h0003);
    xq_enable = '0;
    stb_ext.mss = 1'b1;
    wr(SSUM_OP_PPE_WR, 8'h40);
    pl(16'h0003);
    sre_eq_en = 1'b1;
    pe(ssum_evt_t'(6'h10));
    n = '0;
    repeat (3) begin
      n = n + 16'(srq_q);
      @(negedge clk);
    end
    chk(n, 16'h0001);
    chk(16'(ist_q), 16'h0001);
    stb_ext = '{1'b1, 1'b1, 1'b1, 1'b1};
    repeat (2) @(negedge clk);
    rd(SSUM_OP_STB_RD, 16'h00DC);
    stop_test();
  end
endmodule
`default_nettype wire
